//--- pkg/drv_pkg.sv
// shared constants, types and register map of the read command block
package drv_pkg;
    localparam logic [7:0]  CMD_LOG_DMA  = 8'h47;
    localparam logic [7:0]  CMD_MULT     = 8'hC4;
    localparam logic [7:0]  CMD_MULT_EXT = 8'h29;
    localparam logic [7:0]  LOG_SATA     = 8'h08;
    localparam logic [7:0]  LOG_NAND     = 8'hD9;
    localparam logic [15:0] NAND_LEN     = 16'h0200;
    localparam logic [15:0] SATA_REV     = 16'h0001;
    localparam logic [15:0] QW_VALID     = 16'h8000;
    localparam logic [7:0]  LOG_LAST     = 8'hFF;
    localparam logic [16:0] CNT8_ZERO    = 17'h00100;
    localparam logic [16:0] CNT16_ZERO   = 17'h10000;
    // register byte offsets
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_COUNT = 8'h04;
    localparam logic [7:0] A_LBALO = 8'h08;
    localparam logic [7:0] A_LBAHI = 8'h0C;
    localparam logic [7:0] A_MULT  = 8'h10;
    localparam logic [7:0] A_SET   = 8'h14;
    localparam logic [7:0] A_HFC   = 8'h18;
    localparam logic [7:0] A_SLP   = 8'h1C;
    localparam logic [7:0] A_STAT  = 8'h20;
    localparam logic [7:0] A_OLBLO = 8'h24;
    localparam logic [7:0] A_OLBHI = 8'h28;
    localparam logic [7:0] A_ISTAT = 8'h2C;
    localparam logic [7:0] A_IMASK = 8'h30;
    // status and error byte fields, interrupt bits and reset values
    localparam logic [7:0] ST_OK    = 8'h40;
    localparam int         ST_DF    = 5;
    localparam int         ST_SENSE = 1;
    localparam int         ST_ERR   = 0;
    localparam int         ER_UNC   = 6;
    localparam int         ER_ABT   = 2;
    localparam int         INT_BLK  = 0;
    localparam int         INT_DONE = 1;
    localparam logic [1:0] INT_RST  = 2'h0;
    localparam logic [8:0] MULT_RST = 9'h000;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic        unc;
        logic [15:0] data;
    } med_in_t;

    typedef struct packed {
        logic        valid;
        logic        dma;
        logic [15:0] data;
    } hd_out_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_MREQ  = 3'b001,
        S_MDATA = 3'b010,
        S_LOG   = 3'b011,
        S_END   = 3'b100
    } state_t;
endpackage

//--- test/media_model.sv
// media partner: streams sectors of 16-bit words on request
`timescale 1ns/1ns
module media_model #(
    parameter int WORDS = 4
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_med_req,
    input  wire logic [47:0] i_med_lba,
    input  wire logic        i_med_ready,
    input  wire logic [47:0] i_bad_lba,
    input  wire logic        i_slow,
    output drv_pkg::med_in_t o_med
);
    logic [7:0]  idx;
    logic        act;
    logic        gap;
    logic [15:0] cyc;
    always_comb begin
        o_med.valid = act && !gap;
        o_med.last = idx == 8'(WORDS - 1);
        o_med.unc = i_med_lba == i_bad_lba;
        // idle data keeps moving so a stale word is never mistaken for good
        o_med.data = o_med.valid ? {i_med_lba[7:0], idx} : cyc;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            act <= 1'b0;
            idx <= 8'h00;
            gap <= 1'b0;
            cyc <= 16'h0000;
        end else begin
            cyc <= cyc + 16'h0001;
            if (i_med_req) begin
                act <= 1'b1;
                idx <= 8'h00;
                gap <= 1'b0;
            end else if (o_med.valid && i_med_ready) begin
                idx <= idx + 8'h01;
                gap <= i_slow;
                if (o_med.last) begin
                    act <= 1'b0;
                end
            end else begin
                gap <= 1'b0;
            end
        end
    end
endmodule // media_model

//--- test/tb.sv
// testbench for the read command block
`timescale 1ns/1ns
module tb;
    logic                   clk;
    logic                   rst_b;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [7:0]             paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   dev_fault;
    logic [127:0]           fw;
    drv_pkg::med_in_t       med;
    logic                   med_ready;
    logic                   med_req;
    logic [47:0]            med_lba;
    drv_pkg::hd_out_t       hd;
    logic                   hd_ready;
    logic                   irq;
    logic [47:0]            bad_lba;
    logic                   slow;
    logic                   stall;
    logic                   last_dma;
    logic [15:0]            cap [0:4095];
    int                     n_words = 0;
    int                     n_req = 0;
    int                     base;
    int                     rbase;
    int                     n_tick = 0;
    int                     n_mismatch = 0;
    int                     n_compared = 0;

    drv_read_cmd drv_read_cmd_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_dev_fault(dev_fault),
        .i_nand_fw_ver(fw), .i_med(med), .o_med_ready(med_ready), .o_med_req(med_req),
        .o_med_lba(med_lba), .o_hd(hd), .i_hd_ready(hd_ready), .o_irq(irq));
    media_model #(.WORDS(4)) media_model_i (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_med_req(med_req), .i_med_lba(med_lba), .i_med_ready(med_ready),
        .i_bad_lba(bad_lba), .i_slow(slow), .o_med(med));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        n_tick <= n_tick + 1;
        hd_ready <= !stall || n_tick[1:0] == 2'h0;
        if (med_req) n_req <= n_req + 1;
        if (hd.valid && hd_ready) begin
            cap[n_words % 4096] <= hd.data;
            last_dma <= hd.dma;
            n_words <= n_words + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, x, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h00000000, d, e);
        chk(d, exp, m);
    endtask
    task automatic cw(input int i, input logic [15:0] exp, input string m);
        chk({16'h0000, cap[(base + i) % 4096]}, {16'h0000, exp}, m);
    endtask
    task automatic run(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba);
        logic [31:0] d;
        logic        e;
        int          k;
        base = n_words;
        rbase = n_req;
        wr(drv_pkg::A_COUNT, {16'h0000, cnt});
        wr(drv_pkg::A_LBALO, lba[31:0]);
        wr(drv_pkg::A_LBAHI, {16'h0000, lba[47:32]});
        wr(drv_pkg::A_CMD, {24'h000000, op});
        k = 0;
        d = 32'h00010000;
        while (d[16] !== 1'b0 && k < 20000) begin
            apb(1'b0, drv_pkg::A_STAT, 32'h00000000, d, e);
            k++;
        end
        chk({31'h0, d[16]}, 32'h00000000, "busy stuck");
    endtask

    task automatic t_reg;
        logic [31:0] d;
        logic        e;
        rdc(drv_pkg::A_STAT, 32'h00000040, "status at reset");
        rdc(drv_pkg::A_MULT, 32'h00000000, "mult at reset");
        apb(1'b0, 8'h34, 32'h00000000, d, e);
        chk({31'h0, e}, 32'h00000001, "unmapped error");
        chk(d, 32'h00000000, "unmapped data");
        $display("test registers done");
    endtask
    task automatic t_nomult;
        run(drv_pkg::CMD_MULT, 16'h0002, 48'h000000000100);
        rdc(drv_pkg::A_STAT, 32'h00000441, "abort status");
        chk(n_words - base, 0, "words on abort");
        run(drv_pkg::CMD_MULT_EXT, 16'h0000, 48'h000000000100);
        rdc(drv_pkg::A_STAT, 32'h00000441, "ext abort status");
        $display("test no multiple size done");
    endtask
    task automatic t_mult;
        stall <= 1'b1;
        slow <= 1'b1;
        wr(drv_pkg::A_MULT, 32'h00000002);
        run(drv_pkg::CMD_MULT, 16'h0003, 48'h000000000500);
        chk(n_req - rbase, 3, "sector count");
        chk(n_words - base, 12, "word count");
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                cw(s * 4 + k, {8'(s), 8'(k)}, "sector data");
            end
        end
        chk({31'h0, last_dma}, 32'h00000000, "pio flag");
        rdc(drv_pkg::A_ISTAT, 32'h00000003, "int status");
        chk({31'h0, irq}, 32'h00000000, "irq masked");
        wr(drv_pkg::A_IMASK, 32'h00000001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001, "irq raised");
        wr(drv_pkg::A_ISTAT, 32'h00000001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000, "irq cleared");
        rdc(drv_pkg::A_ISTAT, 32'h00000002, "w1c leaves done");
        stall <= 1'b0;
        slow <= 1'b0;
        $display("test read multiple done");
    endtask
    task automatic t_zero;
        run(drv_pkg::CMD_MULT, 16'h0100, 48'h000000001000);
        chk(n_req - rbase, 256, "zero count sectors");
        chk(n_words - base, 1024, "zero count words");
        cw(1023, 16'hFF03, "last word");
        $display("test zero count done");
    endtask
    task automatic t_ext;
        dev_fault <= 1'b1;
        bad_lba <= 48'h001234567802;
        run(drv_pkg::CMD_MULT_EXT, 16'h0004, 48'h001234567800);
        chk(n_words - base, 8, "stop at bad sector");
        chk(n_req - rbase, 3, "no later sector");
        rdc(drv_pkg::A_STAT, 32'h00004063, "ext error status");
        rdc(drv_pkg::A_OLBLO, 32'h34567802, "failing lba low");
        rdc(drv_pkg::A_OLBHI, 32'h00000012, "failing lba high");
        dev_fault <= 1'b0;
        bad_lba <= 48'hFFFFFFFFFFFF;
        $display("test ext error done");
    endtask
    task automatic t_log;
        logic [47:0] bad [3] = '{48'h000000000108, 48'h000100000008, 48'h000000000007};
        wr(drv_pkg::A_SET, 32'h00005A5D);
        wr(drv_pkg::A_HFC, 32'h00C30017);
        wr(drv_pkg::A_SLP, 32'h0000ABFF);
        run(drv_pkg::CMD_LOG_DMA, 16'h0001, 48'h000000000008);
        chk(n_words - base, 256, "log words");
        chk({31'h0, last_dma}, 32'h00000001, "dma flag");
        cw(8, 16'h1A5D, "settings low");
        cw(11, 16'h8000, "settings top");
        cw(20, 16'h0017, "hfc current");
        cw(21, 16'h00C3, "hfc supported");
        cw(24, 16'hAB1F, "sleep timing");
        cw(27, 16'h8000, "sleep top");
        run(drv_pkg::CMD_LOG_DMA, 16'h0001, 48'h0000000000D9);
        cw(0, 16'hD900, "nand code");
        cw(1, drv_pkg::NAND_LEN, "nand length");
        cw(2, 16'h0001, "nand cache flag");
        cw(8, fw[15:0], "fw first");
        cw(15, fw[127:112], "fw last");
        for (int i = 0; i < 3; i++) begin
            run(drv_pkg::CMD_LOG_DMA, 16'h0001, bad[i]);
            rdc(drv_pkg::A_STAT, 32'h00000441, "log abort");
            chk(n_words - base, 0, "log abort words");
        end
        $display("test log read done");
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        dev_fault = 1'b0;
        fw = 128'h0F0E0D0C0B0A09080706050403020100;
        bad_lba = 48'hFFFFFFFFFFFF;
        slow = 1'b0;
        stall = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reg;
        t_nomult;
        t_mult;
        t_zero;
        t_ext;
        t_log;
        final_report;
    end
endmodule // tb

//--- verilog/drv_read_cmd.sv
// read multiple and dma log read command engine with apb registers
// What this block does
// - log dma read 47h: address and page fields
// - dma log content equals pio log content
// - 8-bit multi read C4h, zero means 256
// - 48-bit multi read 29h, zero means 65536
// - sectors streamed to host, 16 bits each
// - one interrupt per multiple-size block
// - failing read reports first bad lba
// - ext error status: fault, sense, error bits
// - settings qword: bit63 set, speed bits 2:0
// - settings bits 3-13 are feature enables
// - hfc identifiers at bytes 40-43
// - sleep timing qword at bytes 48-55
// - nand page: code, length, flag, firmware
// - uncorrectable error stops at failing sector
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
module drv_read_cmd (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic             i_dev_fault,
    input  wire logic [127:0]     i_nand_fw_ver,
    input  wire drv_pkg::med_in_t i_med,
    output logic                  o_med_ready,
    output logic                  o_med_req,
    output logic      [47:0]      o_med_lba,
    output drv_pkg::hd_out_t      o_hd,
    input  wire logic             i_hd_ready,
    output logic                  o_irq
);
    drv_pkg::state_t state;
    logic [15:0]     cnt_reg;
    logic [47:0]     lba_reg;
    logic [8:0]      mult;
    logic [2:0]      speed;
    logic [10:0]     feat_en;
    logic            nand_backed_cache_enabled;
    logic [15:0]     hfc_cur;
    logic [15:0]     hfc_sup;
    logic [7:0]      sleep_exit_timeout;
    logic [4:0]      min_sleep_assert_time;
    logic [7:0]      stat_byte;
    logic [7:0]      err_byte;
    logic [47:0]     out_lba;
    logic [1:0]      int_stat;
    logic [1:0]      int_mask;
    logic [16:0]     remain;
    logic [8:0]      blk_cnt;
    logic [47:0]     cur_lba;
    logic [7:0]      log_idx;
    logic [7:0]      log_addr;
    logic            is_ext;
    logic            wr_en;
    logic            launch;
    logic            take;
    logic            hd_fire;
    logic            slot_free;
    logic            ev_blk;
    logic            ev_done;
    logic            log_ok;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // one word of a supported log page, used by the dma log read
    function automatic logic [15:0] log_word(input logic [7:0] la, input logic [7:0] i);
        logic [15:0] w;
        w = 16'h0000;
        if (la == drv_pkg::LOG_SATA) begin
            case (i)
                8'h00:                   w = drv_pkg::SATA_REV;
                8'h01:                   w = {8'h00, drv_pkg::LOG_SATA};
                8'h03, 8'h07, 8'h0B:     w = drv_pkg::QW_VALID;
                8'h08:                   w = {2'b00, feat_en, speed};
                8'h14:                   w = hfc_cur;
                8'h15:                   w = hfc_sup;
                8'h18:                   w = {sleep_exit_timeout, 3'b000, min_sleep_assert_time};
                8'h1B:                   w = drv_pkg::QW_VALID;
                default:                 w = 16'h0000;
            endcase
        end else begin
            case (i)
                8'h00:   w = {drv_pkg::LOG_NAND, 8'h00};
                8'h01:   w = drv_pkg::NAND_LEN;
                8'h02:   w = {15'h0000, nand_backed_cache_enabled};
                8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
                    w = i_nand_fw_ver[{i[2:0], 4'h0} +: 16];
                default: w = 16'h0000;
            endcase
        end
        return w;
    endfunction

    assign wr_en     = i_psel && i_penable && o_pready && i_pwrite;
    assign launch    = wr_en && hit(i_paddr, drv_pkg::A_CMD) && state == drv_pkg::S_IDLE;
    assign take      = i_med.valid && o_med_ready;
    assign hd_fire   = o_hd.valid && i_hd_ready;
    assign slot_free = !o_hd.valid || hd_fire;
    // log address in lba 7:0, page number in 15:8 and 39:32
    assign log_ok    = (lba_reg[7:0] == drv_pkg::LOG_SATA || lba_reg[7:0] == drv_pkg::LOG_NAND)
                       && lba_reg[15:8] == 8'h00 && lba_reg[39:32] == 8'h00
                       && cnt_reg == 16'h0001;
    assign ev_blk    = take && i_med.last && !i_med.unc
                       && (blk_cnt + 9'h001 == mult || remain == 17'h00001);
    assign ev_done   = state == drv_pkg::S_END && !o_hd.valid;

    // apb slave, zero wait states, error on address above the interrupt mask offset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && i_paddr > drv_pkg::A_IMASK;
            o_prdata  <= 32'h0000_0000;
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    drv_pkg::A_COUNT: o_prdata <= {16'h0000, cnt_reg};
                    drv_pkg::A_LBALO: o_prdata <= lba_reg[31:0];
                    drv_pkg::A_LBAHI: o_prdata <= {16'h0000, lba_reg[47:32]};
                    drv_pkg::A_MULT:  o_prdata <= {23'h000000, mult};
                    drv_pkg::A_SET:   o_prdata <= {17'h00000, nand_backed_cache_enabled, feat_en, speed};
                    drv_pkg::A_HFC:   o_prdata <= {hfc_sup, hfc_cur};
                    drv_pkg::A_SLP:   o_prdata <= {16'h0000, sleep_exit_timeout, 3'h0, min_sleep_assert_time};
                    drv_pkg::A_STAT:  o_prdata <= {15'h0000, state != drv_pkg::S_IDLE,
                                                   err_byte, stat_byte};
                    drv_pkg::A_OLBLO: o_prdata <= out_lba[31:0];
                    drv_pkg::A_OLBHI: o_prdata <= {16'h0000, out_lba[47:32]};
                    drv_pkg::A_ISTAT: o_prdata <= {30'h00000000, int_stat};
                    drv_pkg::A_IMASK: o_prdata <= {30'h00000000, int_mask};
                    default:          o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software settings and command block
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg  <= 16'h0000;
            lba_reg  <= 48'h0000_0000_0000;
            mult     <= drv_pkg::MULT_RST;
            speed    <= 3'h0;
            feat_en  <= 11'h000;
            nand_backed_cache_enabled      <= 1'b0;
            hfc_cur  <= 16'h0000;
            hfc_sup  <= 16'h0000;
            sleep_exit_timeout     <= 8'h00;
            min_sleep_assert_time     <= 5'h00;
            int_mask <= drv_pkg::INT_RST;
        end else if (wr_en) begin
            case (i_paddr)
                drv_pkg::A_COUNT: cnt_reg <= i_pwdata[15:0];
                drv_pkg::A_LBALO: lba_reg[31:0] <= i_pwdata;
                drv_pkg::A_LBAHI: lba_reg[47:32] <= i_pwdata[15:0];
                drv_pkg::A_MULT:  mult <= i_pwdata[8:0];
                drv_pkg::A_SET: begin
                    speed   <= i_pwdata[2:0];
                    feat_en <= i_pwdata[13:3];
                    nand_backed_cache_enabled     <= i_pwdata[14];
                end
                drv_pkg::A_HFC: begin
                    hfc_cur <= i_pwdata[15:0];
                    hfc_sup <= i_pwdata[31:16];
                end
                drv_pkg::A_SLP: begin
                    sleep_exit_timeout <= i_pwdata[15:8];
                    min_sleep_assert_time <= i_pwdata[4:0];
                end
                drv_pkg::A_IMASK: int_mask <= i_pwdata[1:0];
                default: ;
            endcase
        end
    end

    // sticky interrupt bits, write one to clear, a new event wins
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_stat <= drv_pkg::INT_RST;
            o_irq    <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~((wr_en && hit(i_paddr, drv_pkg::A_ISTAT))
                                      ? i_pwdata[1:0] : 2'b00))
                        | {ev_done, ev_blk};
            o_irq    <= |(int_stat & int_mask);
        end
    end

    // command sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state     <= drv_pkg::S_IDLE;
            remain    <= 17'h00000;
            blk_cnt   <= 9'h000;
            cur_lba   <= 48'h0000_0000_0000;
            log_idx   <= 8'h00;
            log_addr  <= 8'h00;
            is_ext    <= 1'b0;
            stat_byte <= drv_pkg::ST_OK;
            err_byte  <= 8'h00;
            out_lba   <= 48'h0000_0000_0000;
            o_med_req <= 1'b0;
            o_med_lba <= 48'h0000_0000_0000;
        end else begin
            o_med_req <= 1'b0;
            case (state)
                drv_pkg::S_IDLE: begin
                    if (launch) begin
                        stat_byte <= drv_pkg::ST_OK;
                        err_byte  <= 8'h00;
                        cur_lba   <= lba_reg;
                        blk_cnt   <= 9'h000;
                        log_idx   <= 8'h00;
                        log_addr  <= lba_reg[7:0];
                        is_ext    <= i_pwdata[7:0] == drv_pkg::CMD_MULT_EXT;
                        state     <= drv_pkg::S_END;
                        if (i_pwdata[7:0] == drv_pkg::CMD_MULT) begin
                            remain <= (cnt_reg[7:0] == 8'h00) ? drv_pkg::CNT8_ZERO
                                      : {9'h000, cnt_reg[7:0]};
                        end else begin
                            remain <= (cnt_reg == 16'h0000) ? drv_pkg::CNT16_ZERO
                                      : {1'b0, cnt_reg};
                        end
                        if (i_pwdata[7:0] == drv_pkg::CMD_MULT
                            || i_pwdata[7:0] == drv_pkg::CMD_MULT_EXT) begin
                            if (mult != 9'h000) begin
                                state <= drv_pkg::S_MREQ;
                            end else begin
                                stat_byte[drv_pkg::ST_ERR] <= 1'b1;
                                err_byte[drv_pkg::ER_ABT]  <= 1'b1;
                            end
                        end else if (i_pwdata[7:0] == drv_pkg::CMD_LOG_DMA && log_ok) begin
                            state <= drv_pkg::S_LOG;
                        end else begin
                            stat_byte[drv_pkg::ST_ERR] <= 1'b1;
                            err_byte[drv_pkg::ER_ABT]  <= 1'b1;
                        end
                    end
                end
                drv_pkg::S_MREQ: begin
                    o_med_req <= 1'b1;
                    o_med_lba <= cur_lba;
                    state     <= drv_pkg::S_MDATA;
                end
                drv_pkg::S_MDATA: begin
                    if (take && i_med.unc) begin
                        out_lba                    <= cur_lba;
                        err_byte[drv_pkg::ER_UNC]  <= 1'b1;
                        stat_byte[drv_pkg::ST_ERR] <= 1'b1;
                        stat_byte[drv_pkg::ST_SENSE] <= is_ext;
                        stat_byte[drv_pkg::ST_DF]  <= i_dev_fault;
                        state                      <= drv_pkg::S_END;
                    end else if (take && i_med.last) begin
                        cur_lba <= cur_lba + 48'h0000_0000_0001;
                        remain  <= remain - 17'h00001;
                        blk_cnt <= ev_blk ? 9'h000 : blk_cnt + 9'h001;
                        state   <= (remain == 17'h00001) ? drv_pkg::S_END : drv_pkg::S_MREQ;
                    end
                end
                drv_pkg::S_LOG: begin
                    if (slot_free) begin
                        log_idx <= log_idx + 8'h01;
                        if (log_idx == drv_pkg::LOG_LAST) begin
                            state <= drv_pkg::S_END;
                        end
                    end
                end
                drv_pkg::S_END: begin
                    if (!o_hd.valid) begin
                        state <= drv_pkg::S_IDLE;
                    end
                end
                default: state <= drv_pkg::S_IDLE;
            endcase
        end
    end

    // one-word holding slot toward the host data port
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hd        <= '0;
            o_med_ready <= 1'b0;
        end else begin
            o_med_ready <= state == drv_pkg::S_MDATA && !take && slot_free;
            if (take && !i_med.unc) begin
                o_hd.valid <= 1'b1;
                o_hd.dma   <= 1'b0;
                o_hd.data  <= i_med.data;
            end else if (state == drv_pkg::S_LOG && slot_free) begin
                o_hd.valid <= 1'b1;
                o_hd.dma   <= 1'b1;
                o_hd.data  <= log_word(log_addr, log_idx);
            end else if (hd_fire) begin
                o_hd.valid <= 1'b0;
            end
        end
    end

    property p_abort_nomult;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        launch && i_pwdata[7:0] == drv_pkg::CMD_MULT && mult == 9'h000
        |=> state == drv_pkg::S_END && err_byte[drv_pkg::ER_ABT] ##1
            state == drv_pkg::S_IDLE && !o_med_req;
    endproperty
    a_abort_nomult: assert property (p_abort_nomult) else $error("abort without size");

    property p_cnt256;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        launch && i_pwdata[7:0] == drv_pkg::CMD_MULT && cnt_reg[7:0] == 8'h00
        |=> remain == 17'h00100;
    endproperty
    a_cnt256: assert property (p_cnt256) else $error("count zero not 256");

    property p_cnt64k;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        launch && i_pwdata[7:0] == drv_pkg::CMD_MULT_EXT && cnt_reg == 16'h0000
        |=> remain == 17'h10000;
    endproperty
    a_cnt64k: assert property (p_cnt64k) else $error("count zero not 65536");

    property p_unc_stop;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        take && i_med.unc |=> state == drv_pkg::S_END && !o_med_ready
            && out_lba == $past(cur_lba) && stat_byte[drv_pkg::ST_ERR];
    endproperty
    a_unc_stop: assert property (p_unc_stop) else $error("unc read not stopped");

    property p_ext_sense;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        take && i_med.unc && is_ext |=> stat_byte[drv_pkg::ST_SENSE] ##1 !o_med_req;
    endproperty
    a_ext_sense: assert property (p_ext_sense) else $error("ext error status");

    property p_bad_log;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        launch && i_pwdata[7:0] == drv_pkg::CMD_LOG_DMA && !log_ok
        |=> ##1 state == drv_pkg::S_IDLE && stat_byte[drv_pkg::ST_ERR] && !o_hd.valid;
    endproperty
    a_bad_log: assert property (p_bad_log) else $error("bad log not aborted");

    property p_fwd;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        take && !i_med.unc |=> o_hd.valid && o_hd.data == $past(i_med.data) && !o_hd.dma;
    endproperty
    a_fwd: assert property (p_fwd) else $error("sector word lost");

    property p_blk_irq;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        take && i_med.last && !i_med.unc && blk_cnt + 9'h001 == mult
        |=> int_stat[drv_pkg::INT_BLK] && blk_cnt == 9'h000;
    endproperty
    a_blk_irq: assert property (p_blk_irq) else $error("block irq missing");

    property p_irq_out;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        |(int_stat & int_mask) |=> o_irq;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq not raised");
endmodule // drv_read_cmd
